// *** logic/front_panel_led_post_display.v ***
// Purpose: Front panel indicators, self-test code display and configuration
//          switch handling with a small register port and interrupt.
// Assumes: One 50 MHz clock; sys_rst is a warm reset; cold_rst_n low only
//          after a full power cycle.
// Notes:   Red and green drive are separate per bicolor indicator.
`timescale 1ns/1ns
`default_nettype none
`include "front_panel_map.vh"
module front_panel_led_post_display #(
    parameter DWELL_CYCLES = `DWELL_MS * `CLK_KHZ,
    parameter BLINK_CYCLES = `BLINK_MS * `CLK_KHZ
) (
    input  wire        clk,
    input  wire        sys_rst,
    input  wire        cold_rst_n,
    input  wire [3:0]  reg_addr,
    input  wire [7:0]  reg_wdata,
    input  wire        reg_wr,
    input  wire        reg_rd,
    output reg  [7:0]  reg_rdata,
    input  wire [3:0]  board_config_switches,
    input  wire        fault_power,
    input  wire        fault_cpu_cat,
    input  wire        fault_hw_reset,
    input  wire        fault_boot,
    input  wire        cpu_overtemp,
    input  wire        cpu_thermal_trip,
    input  wire        flash_wr_req,
    output reg  [3:0]  general_indicators_green,
    output reg  [3:0]  general_indicators_red,
    output reg         watchdog_indicator,
    output reg         thermal_indicator_red,
    output reg         thermal_indicator_green,
    output reg         flash_std_wr,
    output reg         flash_rec_wr,
    output reg         flash_sel_recovery,
    output reg         reset_config,
    output reg         settings_clear_req,
    output reg         irq
);
    localparam ST_DARK  = 2'h0;
    localparam ST_UPPER = 2'h1;
    localparam ST_LOWER = 2'h2;

    wire [9:0] sync_q;
    wire [3:0] sw_q    = sync_q[3:0];
    wire [3:0] fault_q = sync_q[7:4];
    wire       hot_q   = sync_q[8];
    wire       trip_q  = sync_q[9];
    wire       dwell_tick;
    wire       blink_tick;

    reg  [7:0] code_q;
    reg  [7:0] diag_q;
    reg  [7:0] app_q;
    reg  [3:0] ctrl_q;
    reg  [1:0] state_q;
    reg  [1:0] state_d;
    reg        code_new_q;
    reg        trip_latch_q;
    reg        blink_q;
    reg  [3:0] irq_stat_q;
    reg  [3:0] irq_en_q;
    reg        hot_prev_q;
    reg        clr_prev_q;
    reg  [3:0] nibble;
    reg  [3:0] gen_green_d;
    reg  [7:0] rdata_d;
    wire [3:0] events;

    sync2 #(.W(10)) u_sync (
        .clk      (clk),
        .sys_rst  (sys_rst),
        .async_in ({cpu_thermal_trip, cpu_overtemp, fault_power,
                    fault_cpu_cat, fault_hw_reset, fault_boot,
                    board_config_switches}),
        .sync_out (sync_q)
    );

    tick_gen #(.PERIOD(DWELL_CYCLES)) u_dwell (
        .clk     (clk),
        .sys_rst (sys_rst),
        .restart (code_new_q),
        .tick    (dwell_tick)
    );

    tick_gen #(.PERIOD(BLINK_CYCLES)) u_blink (
        .clk     (clk),
        .sys_rst (sys_rst),
        .restart (1'b0),
        .tick    (blink_tick)
    );

    // Register writes and the code holding register.
    always @(posedge clk)
    begin
        if (sys_rst)
        begin
            code_q     <= 8'h00;
            diag_q     <= 8'h00;
            app_q      <= 8'h00;
            ctrl_q     <= `CTRL_RESET;
            irq_en_q   <= 4'h0;
            code_new_q <= 1'b0;
        end
        else
        begin
            code_new_q <= 1'b0;
            if (reg_wr)
            begin
                case (reg_addr)
                    `REG_CODE:
                    begin
                        code_q     <= reg_wdata;
                        code_new_q <= 1'b1;
                    end
                    `REG_DIAG:       diag_q   <= reg_wdata;
                    `REG_APP:        app_q    <= reg_wdata;
                    `REG_CTRL:       ctrl_q   <= reg_wdata[3:0];
                    `REG_IRQ_ENABLE: irq_en_q <= reg_wdata[3:0];
                    default:         ;
                endcase
            end
        end
    end

    // Display cycle: dark, upper nibble, lower nibble, back to dark.
    always @*
    begin
        state_d = state_q;
        if (code_new_q)
            state_d = ST_DARK;
        else if (dwell_tick)
        begin
            case (state_q)
                ST_DARK:  state_d = ST_UPPER;
                ST_UPPER: state_d = ST_LOWER;
                ST_LOWER: state_d = ST_DARK;
                default:  state_d = ST_DARK;
            endcase
        end
    end

    always @(posedge clk)
    begin
        if (sys_rst)
            state_q <= ST_DARK;
        else
            state_q <= state_d;
    end

    // The same nibble mapping serves both the code and the diagnostic value.
    always @*
    begin
        nibble = 4'h0;
        if (!ctrl_q[`CTRL_BOOT_DONE])
        begin
            if (sw_q[0])
            begin
                case (state_q)
                    ST_UPPER: nibble = code_q[7:4];
                    ST_LOWER: nibble = code_q[3:0];
                    default:  nibble = 4'h0;
                endcase
            end
            gen_green_d = nibble;
        end
        else if (ctrl_q[`CTRL_DIAG_SEL])
        begin
            case (state_q)
                ST_UPPER: nibble = diag_q[7:4];
                ST_LOWER: nibble = diag_q[3:0];
                default:  nibble = 4'h0;
            endcase
            gen_green_d = nibble;
        end
        else
            gen_green_d = app_q[3:0];
    end

    // The trip latch ignores the warm reset; only a cold restart clears it,
    // so a watchdog or button reset cannot hide a damaging event.
    always @(posedge clk)
    begin
        if (!cold_rst_n)
            trip_latch_q <= 1'b0;
        else if (trip_q)
            trip_latch_q <= 1'b1;
    end

    always @(posedge clk)
    begin
        if (sys_rst)
            blink_q <= 1'b0;
        else if (blink_tick)
            blink_q <= ~blink_q;
    end

    // Sticky interrupt flags; a new event wins over a clear in one cycle.
    assign events = {sw_q[3] & ~clr_prev_q, trip_q & ~trip_latch_q,
                     hot_q & ~hot_prev_q, code_new_q};

    always @(posedge clk)
    begin
        if (sys_rst)
        begin
            irq_stat_q <= 4'h0;
            hot_prev_q <= 1'b0;
            clr_prev_q <= 1'b0;
        end
        else
        begin
            hot_prev_q <= hot_q;
            clr_prev_q <= sw_q[3];
            if (reg_wr && reg_addr == `REG_IRQ_CLEAR)
                irq_stat_q <= (irq_stat_q & ~reg_wdata[3:0]) | events;
            else
                irq_stat_q <= irq_stat_q | events;
        end
    end

    always @*
    begin
        case (reg_addr)
            `REG_CODE:       rdata_d = code_q;
            `REG_DIAG:       rdata_d = diag_q;
            `REG_APP:        rdata_d = app_q;
            `REG_CTRL:       rdata_d = {4'h0, ctrl_q};
            `REG_STATUS:     rdata_d = {trip_latch_q, hot_q, state_q, sw_q};
            `REG_IRQ_STATUS: rdata_d = {4'h0, irq_stat_q};
            `REG_IRQ_ENABLE: rdata_d = {4'h0, irq_en_q};
            default:         rdata_d = 8'h00;
        endcase
    end

    // Registered outputs.
    always @(posedge clk)
    begin
        if (sys_rst)
        begin
            reg_rdata                <= 8'h00;
            general_indicators_green <= 4'h0;
            general_indicators_red   <= 4'h0;
            watchdog_indicator       <= 1'b0;
            thermal_indicator_red    <= 1'b0;
            thermal_indicator_green  <= 1'b0;
            flash_std_wr             <= 1'b0;
            flash_rec_wr             <= 1'b0;
            flash_sel_recovery       <= 1'b0;
            reset_config             <= 1'b0;
            settings_clear_req       <= 1'b0;
            irq                      <= 1'b0;
        end
        else
        begin
            reg_rdata <= reg_rd ? rdata_d : 8'h00;
            general_indicators_green <= gen_green_d;
            // Red fault flags show only before firmware marks boot done.
            general_indicators_red <= ctrl_q[`CTRL_BOOT_DONE] ? 4'h0 :
                                      fault_q;
            watchdog_indicator <= ctrl_q[`CTRL_WD_ACTIVE];
            if (trip_latch_q)
            begin
                thermal_indicator_red   <= blink_q;
                thermal_indicator_green <= 1'b0;
            end
            else
            begin
                thermal_indicator_red   <= hot_q;
                thermal_indicator_green <= ~hot_q;
            end
            flash_sel_recovery <= sw_q[1];
            flash_std_wr <= flash_wr_req & ~ctrl_q[`CTRL_WP_EN]
                            & ~sw_q[1];
            flash_rec_wr <= flash_wr_req & ~ctrl_q[`CTRL_WP_EN]
                            & sw_q[1];
            reset_config       <= sw_q[2];
            settings_clear_req <= sw_q[3];
            irq <= |(irq_stat_q & irq_en_q);
        end
    end
endmodule // front_panel_led_post_display
`default_nettype wire

// *** logic/front_panel_map.vh ***
// Purpose: Register offsets, field positions, reset values and timing for
//          the front panel indicator and configuration switch block.
// Assumes: 50 MHz clock, plain register port with 4-bit word index.
// Notes:
`ifndef FRONT_PANEL_MAP_VH
`define FRONT_PANEL_MAP_VH

`define REG_CODE        4'h0
`define REG_DIAG        4'h1
`define REG_APP         4'h2
`define REG_CTRL        4'h3
`define REG_STATUS      4'h4
`define REG_IRQ_STATUS  4'h5
`define REG_IRQ_CLEAR   4'h6
`define REG_IRQ_ENABLE  4'h7

`define CTRL_BOOT_DONE  0
`define CTRL_DIAG_SEL   1
`define CTRL_WP_EN      2
`define CTRL_WD_ACTIVE  3
`define CTRL_RESET      4'h0

`define EV_CODE         0
`define EV_OVERTEMP     1
`define EV_TRIP         2
`define EV_CLEAR_REQ    3

`define DWELL_MS        500
`define BLINK_MS        250
`define CLK_KHZ         50000

`endif

// *** logic/sync2.v ***
// Purpose: Two flip-flop synchroniser for a vector of asynchronous levels.
// Assumes: Inputs change slowly relative to clk.
// Notes:   The first stage feeds only the second stage.
`timescale 1ns/1ns
`default_nettype none
module sync2 #(
    parameter W = 8
) (
    input  wire         clk,
    input  wire         sys_rst,
    input  wire [W-1:0] async_in,
    output reg  [W-1:0] sync_out
);
    reg [W-1:0] meta_q;

    always @(posedge clk)
    begin
        if (sys_rst)
        begin
            meta_q   <= {W{1'b0}};
            sync_out <= {W{1'b0}};
        end
        else
        begin
            meta_q   <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule // sync2
`default_nettype wire

// *** logic/tick_gen.v ***
// Purpose: Free running divider giving a one-cycle tick every PERIOD cycles.
// Assumes: PERIOD is at least 2.
// Notes:   A restart pulse realigns the count so a fresh state gets its full
//          dwell.
`timescale 1ns/1ns
`default_nettype none
module tick_gen #(
    parameter PERIOD = 25000000
) (
    input  wire clk,
    input  wire sys_rst,
    input  wire restart,
    output reg  tick
);
    reg [31:0] cnt_q;

    always @(posedge clk)
    begin
        if (sys_rst || restart)
        begin
            cnt_q <= 32'h0;
            tick  <= 1'b0;
        end
        else if (cnt_q == PERIOD - 1)
        begin
            cnt_q <= 32'h0;
            tick  <= 1'b1;
        end
        else
        begin
            cnt_q <= cnt_q + 32'h1;
            tick  <= 1'b0;
        end
    end
endmodule // tick_gen
`default_nettype wire

// *** sim/board_panel.sv ***
// Purpose: Front panel switches and board status sources.
// Assumes: Levels change only just after a rising clock edge.
// Notes:   Levels hold until the bench asks for new ones.
`timescale 1ns/1ns
`default_nettype none
module board_panel (
    input  wire logic       clk,
    output var  logic [3:0] sw,
    output var  logic [3:0] fault,
    output var  logic       hot,
    output var  logic       trip
);
    initial {sw, fault, hot, trip} = 10'h000;
    task automatic put(input logic [9:0] v);
        @(posedge clk);
        {sw, fault, hot, trip} <= v;
    endtask
endmodule // board_panel
`default_nettype wire

// *** sim/front_panel_checker.sv ***
// Purpose: Port-level checks for the front panel indicator block.
// Assumes: One clock; sys_rst disables every check.
// Notes:   Switch paths get a few edges for their synchronisers.
`timescale 1ns/1ns
`default_nettype none
module front_panel_checker (
    input wire logic       clk,
    input wire logic       sys_rst,
    input wire logic [3:0] reg_addr,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic [3:0] board_config_switches,
    input wire logic       cpu_thermal_trip,
    input wire logic       flash_wr_req,
    input wire logic [3:0] general_indicators_green,
    input wire logic       thermal_indicator_red,
    input wire logic       thermal_indicator_green,
    input wire logic       flash_std_wr,
    input wire logic       flash_rec_wr,
    input wire logic       flash_sel_recovery,
    input wire logic       settings_clear_req
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    sequence s_code_wr;
        reg_wr && reg_addr == 4'h0;
    endsequence
    property p_rd_idle;
        !$past(reg_rd) |-> reg_rdata == 8'h00;
    endproperty
    a_rd_idle: assert property (p_rd_idle)
        else $error("read data not idle");
    property p_code_dark;
        s_code_wr |-> ##[1:3] general_indicators_green == 4'h0;
    endproperty
    a_code_dark: assert property (p_code_dark)
        else $error("display not restarted dark");
    property p_wp;
        flash_std_wr || flash_rec_wr |-> $past(flash_wr_req);
    endproperty
    a_wp: assert property (p_wp)
        else $error("flash write without request");
    property p_rec;
        flash_rec_wr |-> flash_sel_recovery && !flash_std_wr;
    endproperty
    a_rec: assert property (p_rec)
        else $error("flash write to wrong image");
    property p_therm;
        !(thermal_indicator_red && thermal_indicator_green);
    endproperty
    a_therm: assert property (p_therm)
        else $error("thermal lamp both colours");
    property p_sel;
        $rose(board_config_switches[1]) |-> ##[1:5] flash_sel_recovery;
    endproperty
    a_sel: assert property (p_sel)
        else $error("image select not followed");
    property p_clr;
        $rose(board_config_switches[3]) |-> ##[1:5] settings_clear_req;
    endproperty
    a_clr: assert property (p_clr)
        else $error("clear request not followed");
    property p_trip;
        $rose(cpu_thermal_trip) |-> ##[1:5] !thermal_indicator_green;
    endproperty
    a_trip: assert property (p_trip)
        else $error("trip left thermal lamp green");
endmodule // front_panel_checker
bind front_panel_led_post_display front_panel_checker u_chk (
    .clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .board_config_switches(board_config_switches),
    .cpu_thermal_trip(cpu_thermal_trip), .flash_wr_req(flash_wr_req),
    .general_indicators_green(general_indicators_green),
    .thermal_indicator_red(thermal_indicator_red),
    .thermal_indicator_green(thermal_indicator_green),
    .flash_std_wr(flash_std_wr), .flash_rec_wr(flash_rec_wr),
    .flash_sel_recovery(flash_sel_recovery),
    .settings_clear_req(settings_clear_req));
`default_nettype wire

// *** sim/tb_front_panel_led_post_display.sv ***
// Purpose: Self-checking bench for the front panel indicator block.
// Assumes: Short dwell and blink counts; firmware uses the reg port.
// Notes:   Waits on indicators are bounded so a stuck display fails.
`timescale 1ns/1ns
`default_nettype none
module tb_front_panel_led_post_display;
    logic       clk = 1'b0, sys_rst = 1'b1, cold_rst_n = 1'b0;
    logic [3:0] reg_addr = 4'h0, sw, fault, grn, red;
    logic [7:0] reg_wdata = 8'h00, reg_rdata;
    logic       reg_wr = 1'b0, reg_rd = 1'b0, flash_wr_req = 1'b0;
    logic       hot, trip, wd, th_r, th_g, f_std, f_rec, f_sel, rcfg;
    logic       sclr, irq;
    int         n_fail = 0, num_checks = 0;
    board_panel u_board (.clk(clk), .sw(sw), .fault(fault), .hot(hot),
        .trip(trip));
    front_panel_led_post_display #(.DWELL_CYCLES(8), .BLINK_CYCLES(4))
    u_dut (.clk(clk), .sys_rst(sys_rst), .cold_rst_n(cold_rst_n),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .board_config_switches(sw), .fault_power(fault[3]),
        .fault_cpu_cat(fault[2]), .fault_hw_reset(fault[1]),
        .fault_boot(fault[0]), .cpu_overtemp(hot),
        .cpu_thermal_trip(trip), .flash_wr_req(flash_wr_req),
        .general_indicators_green(grn), .general_indicators_red(red),
        .watchdog_indicator(wd), .thermal_indicator_red(th_r),
        .thermal_indicator_green(th_g), .flash_std_wr(f_std),
        .flash_rec_wr(f_rec), .flash_sel_recovery(f_sel),
        .reset_config(rcfg), .settings_clear_req(sclr), .irq(irq));
    initial forever #10 clk = ~clk;
    task automatic finish_test;
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [7:0] e, g);
        num_checks++;
        if (g !== e)
        begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] e,
                      input string nm);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 chk(nm, e, reg_rdata);
    endtask
    // A display state lasts the dwell, so a change is due within 20.
    task automatic step(input logic [3:0] e);
        logic [3:0] p;
        int         k;
        p = grn;
        k = 0;
        while (grn === p && k++ < 20) #20;
        chk("green next", {4'h0, e}, {4'h0, grn});
    endtask
    task automatic seq(input logic [3:0] hi, lo);
        int k;
        k = 0;
        while (grn !== hi && k++ < 60) #20;
        chk("green high", {4'h0, hi}, {4'h0, grn});
        step(lo);
        step(4'h0);
    endtask
    task automatic flash(input logic es, er);
        logic s, r;
        s = 1'b0;
        r = 1'b0;
        @(posedge clk);
        flash_wr_req <= 1'b1;
        @(posedge clk);
        flash_wr_req <= 1'b0;
        repeat (3)
        begin
            #1 s |= f_std;
            r |= f_rec;
            @(posedge clk);
        end
        #1 chk("flash", {6'h0, es, er}, {6'h0, s, r});
    endtask
    task automatic blink(input logic e);
        int   t;
        logic p;
        t = 0;
        repeat (20)
        begin
            p = th_r;
            #20 t += (th_r !== p);
        end
        chk("blink", {7'h0, e}, {7'h0, t >= 3 && th_g === 1'b0});
    endtask
    initial
    begin
        #100000 n_fail++;
        finish_test;
    end
    initial
    begin
        repeat (5) @(posedge clk);
        sys_rst <= 1'b0;
        cold_rst_n <= 1'b1;
        cyc(1);
        rd(4'h3, 8'h00, "ctrl reset");
        rd(4'h8, 8'h00, "unmapped");
        chk("watchdog", 8'h00, {7'h0, wd});
        u_board.put(10'h040);
        wr(4'h7, 8'h01);
        wr(4'h0, 8'h41);
        rd(4'h5, 8'h01, "irq status");
        chk("irq", 8'h01, {7'h0, irq});
        seq(4'h4, 4'h1);
        wr(4'h6, 8'h0f);
        cyc(2);
        chk("irq clear", 8'h00, {7'h0, irq});
        wr(4'h7, 8'h00);
        wr(4'h0, 8'h41);
        cyc(2);
        chk("irq mask", 8'h00, {7'h0, irq});
        u_board.put(10'h024);
        cyc(40);
        chk("green off", 8'h00, {4'h0, grn});
        chk("red faults", 8'h09, {4'h0, red});
        u_board.put(10'h000);
        wr(4'h3, 8'h01);
        wr(4'h2, 8'h05);
        cyc(3);
        chk("green app", 8'h05, {4'h0, grn});
        wr(4'h1, 8'h93);
        wr(4'h3, 8'h03);
        seq(4'h9, 4'h3);
        wr(4'h3, 8'h09);
        cyc(2);
        chk("watchdog", 8'h01, {7'h0, wd});
        wr(4'h3, 8'h01);
        u_board.put(10'h002);
        cyc(5);
        chk("hot", 8'h02, {6'h0, th_r, th_g});
        u_board.put(10'h000);
        cyc(5);
        chk("cool", 8'h01, {6'h0, th_r, th_g});
        flash(1'b1, 1'b0);
        u_board.put(10'h380);
        cyc(5);
        chk("switches", 8'h07, {5'h0, f_sel, rcfg, sclr});
        flash(1'b0, 1'b1);
        wr(4'h3, 8'h05);
        flash(1'b0, 1'b0);
        u_board.put(10'h001);
        cyc(6);
        blink(1'b1);
        rd(4'h5, 8'h0f, "irq events");
        u_board.put(10'h000);
        sys_rst <= 1'b1;
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        cyc(6);
        blink(1'b1);
        @(posedge clk);
        cold_rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        cold_rst_n <= 1'b1;
        cyc(6);
        blink(1'b0);
        finish_test;
    end
endmodule // tb_front_panel_led_post_display
`default_nettype wire
